/* inc/axis_limit_pkg.sv */
package axis_limit_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_DECEL     = 8'h04;
  localparam logic [7:0] OFS_LIM_DECEL = 8'h08;
  localparam logic [7:0] OFS_STATUS    = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h14;
  localparam logic [7:0] OFS_FREQ      = 8'h18;

  // Control field positions
  localparam int CTRL_SEL_LSB   = 0;
  localparam int CTRL_FWD_INV   = 4;
  localparam int CTRL_REV_INV   = 5;
  localparam int CTRL_HOLD_ZERO = 6;

  // Reset values
  localparam logic [1:0]  SEL_RST       = 2'h0;
  localparam logic [15:0] DECEL_RST     = 16'h0010;
  localparam logic [15:0] LIM_DECEL_RST = 16'h0040;
  localparam logic        HOLD_ZERO_RST = 1'b0;

  // Ramp step rate: one step every RAMP_DIV cycles
  localparam int RAMP_DIV = 100;

  // Interrupt bit positions
  localparam int IRQ_FWD_LIM = 0;
  localparam int IRQ_REV_LIM = 1;
  localparam int IRQ_STOPPED = 2;
  localparam int IRQ_BAD_SEL = 3;
  localparam int IRQ_W       = 4;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_STOP = 2'b10,
    ST_LIM  = 2'b11
  } ramp_state_e;

  typedef struct packed {
    logic run_fwd;
    logic run_rev;
    logic lim_fwd;
    logic lim_rev;
  } contacts_s;

endpackage : axis_limit_pkg

/* rtl/ramp_tick.sv */
module ramp_tick #(
  parameter int DIV = axis_limit_pkg::RAMP_DIV
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  output logic      tick_o
);
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;

  // Divider next value
  always_comb begin
    if (cnt_reg == 16'(DIV - 1)) begin
      cnt_next = 16'h0000;
    end else begin
      cnt_next = cnt_reg + 16'h0001;
    end
  end

  // Divider register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= 16'h0000;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign tick_o = (cnt_reg == 16'(DIV - 1));
endmodule : ramp_tick

/* rtl/limit_sense.sv */
module limit_sense (
  input  wire logic raw_i,
  input  wire logic invert_i,
  output logic      active_o
);
  // Normally open unless inverted to normally closed
  assign active_o = raw_i ^ invert_i;
endmodule : limit_sense

/* rtl/axis_limit_stop_control.sv */
// Behaviour
// - Axis-limit control is permanent; no input switches back to plain mode.
// - With analog input 1, bipolar or unipolar operation follows only from the wired contacts.
// - There is no jog operation.
// - Selector 0 or 1 takes analog input 1, bipolar or unipolar.
// - Selector 2 takes analog input 2 unipolar only; 3 is invalid.
// - Limits are normally open; an invert bit of 1 makes one normally closed.
// - Run removal or falling reference ramps down at the normal rate.
// - Stopping at a travel limit uses the separate limit rate.
// - The fast ramp mode decelerates continuously.
// - Hold zero speed resets to 0, leaving the motor free.
// - Limit and run indicators are read only.
// - A limit reaching the axis end ramps the motor to zero speed.
// - The motor runs only while exactly one run contact is closed; run forward follows a bipolar reference's sign.
module axis_limit_stop_control (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic [7:0]                wb_adr_i,
  input  wire logic [31:0]               wb_dat_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic                      wb_we_i,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  input  wire axis_limit_pkg::contacts_s contacts_i,
  input  wire logic signed [15:0]        ain1_i,
  input  wire logic [15:0]               ain2_i,
  output logic signed [15:0]             freq_o,
  output logic                           hold_torque_o,
  output logic                           irq_o
);
  localparam int IRQ_W_L = axis_limit_pkg::IRQ_W;

  logic [1:0]             sel_reg, sel_next;
  logic                   fwd_inv_reg, fwd_inv_next;
  logic                   rev_inv_reg, rev_inv_next;
  logic                   hold_reg, hold_next;
  logic [15:0]            decel_reg, decel_next;
  logic [15:0]            lim_decel_reg, lim_decel_next;
  logic [IRQ_W_L-1:0]     ist_reg, ist_next;
  logic [IRQ_W_L-1:0]     imask_reg, imask_next;
  logic                   ack_reg, ack_next;
  logic [31:0]            rdat_reg, rdat_next;
  logic signed [15:0]     freq_reg, freq_next;
  axis_limit_pkg::ramp_state_e st_reg, st_next;
  logic                   lf_prev_reg, lr_prev_reg;
  logic                   lim_fwd, lim_rev, tick;
  logic signed [15:0]     ref_raw, target;
  logic                   wr, rd, bad_sel;
  logic [IRQ_W_L-1:0]     ev;

  ramp_tick u_tick (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_o (tick)
  );

  limit_sense u_lf (
    .raw_i    (contacts_i.lim_fwd),
    .invert_i (fwd_inv_reg),
    .active_o (lim_fwd)
  );

  limit_sense u_lr (
    .raw_i    (contacts_i.lim_rev),
    .invert_i (rev_inv_reg),
    .active_o (lim_rev)
  );

  // Reference source selection; no mode or jog input exists
  always_comb begin
    bad_sel = 1'b0;
    case (sel_reg)
      2'h0, 2'h1: ref_raw = ain1_i;
      2'h2: ref_raw = $signed({1'b0, ain2_i[15:1]});
      default: begin
        ref_raw = 16'sh0000;
        bad_sel = 1'b1;
      end
    endcase
  end

  // Target from run contacts and limits; bipolar sign from reference
  always_comb begin
    target = 16'sh0000;
    if (contacts_i.run_fwd && !contacts_i.run_rev) begin
      target = ref_raw;
    end else if (contacts_i.run_rev && !contacts_i.run_fwd) begin
      target = (ref_raw < 0) ? 16'sh0000 : -ref_raw;
    end
    if (target > 0 && lim_fwd) begin
      target = 16'sh0000;
    end
    if (target < 0 && lim_rev) begin
      target = 16'sh0000;
    end
  end

  // Fast ramp: step toward target each tick, limit rate when moving into an active limit
  always_comb begin
    logic [15:0] rate;
    logic signed [16:0] diff;
    logic signed [16:0] step;
    rate = decel_reg;
    diff = 17'(target) - 17'(freq_reg);
    step = 17'sh00000;
    st_next = st_reg;
    freq_next = freq_reg;
    if ((freq_reg > 0 && lim_fwd) || (freq_reg < 0 && lim_rev)) begin
      st_next = axis_limit_pkg::ST_LIM;
      rate = lim_decel_reg;
    end else if (target == 16'sh0000 && freq_reg != 16'sh0000) begin
      st_next = axis_limit_pkg::ST_STOP;
    end else if (freq_reg == 16'sh0000 && target == 16'sh0000) begin
      st_next = axis_limit_pkg::ST_IDLE;
    end else begin
      st_next = axis_limit_pkg::ST_RUN;
    end
    // Signed step so a falling ramp never compares as unsigned
    step = $signed({1'b0, rate});
    if (tick) begin
      if (diff > step) begin
        freq_next = 16'(17'(freq_reg) + step);
      end else if (diff < -step) begin
        freq_next = 16'(17'(freq_reg) - step);
      end else begin
        freq_next = target;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg      <= axis_limit_pkg::ST_IDLE;
      freq_reg    <= 16'sh0000;
      lf_prev_reg <= 1'b0;
      lr_prev_reg <= 1'b0;
    end else begin
      st_reg      <= st_next;
      freq_reg    <= freq_next;
      lf_prev_reg <= lim_fwd;
      lr_prev_reg <= lim_rev;
    end
  end

  // Events
  always_comb begin
    ev = '0;
    ev[axis_limit_pkg::IRQ_FWD_LIM] = lim_fwd && !lf_prev_reg;
    ev[axis_limit_pkg::IRQ_REV_LIM] = lim_rev && !lr_prev_reg;
    ev[axis_limit_pkg::IRQ_STOPPED] = (freq_reg != 16'sh0000) &&
                                      (freq_next == 16'sh0000);
    ev[axis_limit_pkg::IRQ_BAD_SEL] = bad_sel;
  end

  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_reg;
  assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_reg;

  // Register file next values; indicators have no write path
  always_comb begin
    sel_next       = sel_reg;
    fwd_inv_next   = fwd_inv_reg;
    rev_inv_next   = rev_inv_reg;
    hold_next      = hold_reg;
    decel_next     = decel_reg;
    lim_decel_next = lim_decel_reg;
    imask_next     = imask_reg;
    ist_next       = ist_reg;
    rdat_next      = 32'h0000_0000;
    ack_next       = wb_cyc_i && wb_stb_i && !ack_reg;
    if (wr) begin
      case (wb_adr_i)
        axis_limit_pkg::OFS_CTRL: if (wb_sel_i[0]) begin
          sel_next     = wb_dat_i[axis_limit_pkg::CTRL_SEL_LSB +: 2];
          fwd_inv_next = wb_dat_i[axis_limit_pkg::CTRL_FWD_INV];
          rev_inv_next = wb_dat_i[axis_limit_pkg::CTRL_REV_INV];
          hold_next    = wb_dat_i[axis_limit_pkg::CTRL_HOLD_ZERO];
        end
        axis_limit_pkg::OFS_DECEL: begin
          if (wb_sel_i[0]) decel_next[7:0]  = wb_dat_i[7:0];
          if (wb_sel_i[1]) decel_next[15:8] = wb_dat_i[15:8];
        end
        axis_limit_pkg::OFS_LIM_DECEL: begin
          if (wb_sel_i[0]) lim_decel_next[7:0]  = wb_dat_i[7:0];
          if (wb_sel_i[1]) lim_decel_next[15:8] = wb_dat_i[15:8];
        end
        axis_limit_pkg::OFS_IRQ_STAT: if (wb_sel_i[0]) begin
          ist_next = ist_reg & ~wb_dat_i[IRQ_W_L-1:0];
        end
        axis_limit_pkg::OFS_IRQ_MASK: if (wb_sel_i[0]) begin
          imask_next = wb_dat_i[IRQ_W_L-1:0];
        end
        default: ;
      endcase
    end
    ist_next = ist_next | ev;           // Set wins over clear
    if (rd) begin
      case (wb_adr_i)
        axis_limit_pkg::OFS_CTRL: rdat_next = {25'h0, hold_reg,
          rev_inv_reg, fwd_inv_reg, 2'h0, sel_reg};
        axis_limit_pkg::OFS_DECEL:     rdat_next = {16'h0, decel_reg};
        axis_limit_pkg::OFS_LIM_DECEL: rdat_next = {16'h0, lim_decel_reg};
        axis_limit_pkg::OFS_STATUS: rdat_next = {26'h0, st_reg,
          lim_rev, contacts_i.run_rev, contacts_i.run_fwd, lim_fwd};
        axis_limit_pkg::OFS_IRQ_STAT: rdat_next = {28'h0, ist_reg};
        axis_limit_pkg::OFS_IRQ_MASK: rdat_next = {28'h0, imask_reg};
        axis_limit_pkg::OFS_FREQ: rdat_next = {16'h0, freq_reg};
        default: rdat_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_reg       <= axis_limit_pkg::SEL_RST;
      fwd_inv_reg   <= 1'b0;
      rev_inv_reg   <= 1'b0;
      hold_reg      <= axis_limit_pkg::HOLD_ZERO_RST;
      decel_reg     <= axis_limit_pkg::DECEL_RST;
      lim_decel_reg <= axis_limit_pkg::LIM_DECEL_RST;
      ist_reg       <= '0;
      imask_reg     <= '0;
      ack_reg       <= 1'b0;
      rdat_reg      <= 32'h0000_0000;
    end else begin
      sel_reg       <= sel_next;
      fwd_inv_reg   <= fwd_inv_next;
      rev_inv_reg   <= rev_inv_next;
      hold_reg      <= hold_next;
      decel_reg     <= decel_next;
      lim_decel_reg <= lim_decel_next;
      ist_reg       <= ist_next;
      imask_reg     <= imask_next;
      ack_reg       <= ack_next;
      rdat_reg      <= rdat_next;
    end
  end

  assign wb_ack_o      = ack_reg;
  assign wb_dat_o      = rdat_reg;
  assign freq_o        = freq_reg;
  assign hold_torque_o = hold_reg && (freq_reg == 16'sh0000);
  assign irq_o         = |(ist_reg & imask_reg);

  // Checks
  sequence s_fwd_lim_moving;
    lim_fwd && freq_reg > 0 && tick;
  endsequence

  AST_LIM_RATE: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_fwd_lim_moving and (freq_reg > $signed(lim_decel_reg))) |=>
      freq_reg == $past(freq_reg) - $signed($past(lim_decel_reg)))
    else $error("limit rate not applied");

  AST_FWD_BLOCK: assert property (@(posedge clk_i) disable iff (rst_i)
    lim_fwd |-> target <= 0)
    else $error("forward travel not blocked");

  AST_REV_BLOCK: assert property (@(posedge clk_i) disable iff (rst_i)
    lim_rev |-> target >= 0)
    else $error("reverse travel not blocked");

  AST_NO_RUN: assert property (@(posedge clk_i) disable iff (rst_i)
    !contacts_i.run_fwd && !contacts_i.run_rev |-> target == 0)
    else $error("target without run contact");

  AST_NORM_RATE: assert property (@(posedge clk_i) disable iff (rst_i)
    tick && st_next == axis_limit_pkg::ST_STOP &&
    freq_reg > $signed(decel_reg) |=>
      freq_reg == $past(freq_reg) - $signed($past(decel_reg)))
    else $error("normal rate not applied");

  AST_BAD_SEL: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_reg == 2'h3 |=> ist_reg[axis_limit_pkg::IRQ_BAD_SEL])
    else $error("invalid selector not flagged");

  AST_SEL2_UNI: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_reg == 2'h2 |-> ref_raw >= 0)
    else $error("input 2 not unipolar");

  AST_SEL01: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_reg <= 2'h1 |-> ref_raw == ain1_i)
    else $error("input 1 not selected");

  AST_HOLD_RST: assert property (@(posedge clk_i)
    $fell(rst_i) |-> !hold_reg)
    else $error("hold zero not cleared by reset");

  AST_INV: assert property (@(posedge clk_i) disable iff (rst_i)
    lim_fwd == (contacts_i.lim_fwd ^ fwd_inv_reg))
    else $error("limit polarity wrong");

  sequence s_fwd_lim_rise;
    lim_fwd && !lf_prev_reg;
  endsequence

  AST_LIM_EV: assert property (@(posedge clk_i) disable iff (rst_i)
    s_fwd_lim_rise |=> ist_reg[axis_limit_pkg::IRQ_FWD_LIM])
    else $error("limit event not recorded");

  AST_STILL: assert property (@(posedge clk_i) disable iff (rst_i)
    !tick |=> freq_reg == $past(freq_reg))
    else $error("ramp moved off its step tick");

  AST_HOLD_FREE: assert property (@(posedge clk_i) disable iff (rst_i)
    !hold_reg |-> !hold_torque_o)
    else $error("torque held while hold disabled");
endmodule : axis_limit_stop_control

/* verif/operator_contacts.sv */
module operator_contacts (
  input  wire logic                 clk_i,
  output axis_limit_pkg::contacts_s contacts_o,
  output logic signed [15:0]        ain1_o,
  output logic        [15:0]        ain2_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // All contacts open, no reference
  initial begin
    contacts_o = '0;
    ain1_o = '0;
    ain2_o = '0;
  end

  // Open both run contacts for a cycle before closing the new one
  task automatic run(input logic fwd, input logic rev);
    contacts_o.run_fwd <= 1'b0;
    contacts_o.run_rev <= 1'b0;
    @(posedge clk_i);
    contacts_o.run_fwd <= fwd;
    contacts_o.run_rev <= rev; // Bipolar callers keep it open
    @(posedge clk_i);
  endtask : run

  // Contact level at the axis end, normally open or closed
  task automatic limit(input logic [1:0] hit, input logic [1:0] nc);
    contacts_o.lim_fwd <= hit[1] ^ nc[1];
    contacts_o.lim_rev <= hit[0] ^ nc[0];
    @(posedge clk_i);
  endtask : limit

  task automatic refs(input logic [15:0] a1, input logic [15:0] a2);
    ain1_o <= a1;
    ain2_o <= a2;
    @(posedge clk_i);
  endtask : refs
endmodule : operator_contacts

/* verif/tb_axis_limit_stop_control.sv */
module tb_axis_limit_stop_control;
  timeunit 1ns;
  timeprecision 1ns;

  logic                      clk_i  = 1'b0;
  logic                      rst_i  = 1'b1;
  logic [7:0]                wb_adr = '0;
  logic [31:0]               wb_dat = '0;
  logic                      wb_we  = 1'b0;
  logic                      wb_cyc = 1'b0;
  logic                      wb_stb = 1'b0;
  logic [31:0]               wb_rdat;
  logic                      wb_ack;
  logic [31:0]               rd_dat;
  axis_limit_pkg::contacts_s contacts;
  logic signed [15:0]        ain1;
  logic [15:0]               ain2;
  logic signed [15:0]        freq;
  logic                      hold_torque;
  logic                      irq;
  int                        errors = 0;
  int                        tests_run = 0;

  // 10 MHz clock
  always #50 clk_i = ~clk_i;

  operator_contacts op_u (
    .clk_i(clk_i), .contacts_o(contacts), .ain1_o(ain1), .ain2_o(ain2)
  );

  axis_limit_stop_control dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat),
    .wb_sel_i(4'hf), .wb_we_i(wb_we), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .contacts_i(contacts), .ain1_i(ain1), .ain2_i(ain2), .freq_o(freq),
    .hold_torque_o(hold_torque), .irq_o(irq)
  );

  task automatic give_verdict;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Classic single cycle, held until ack is sampled
  task automatic bus(input logic [7:0] a, input logic we,
                     input logic [31:0] d);
    int n;
    n = 0;
    wb_adr <= a;
    wb_we  <= we;
    wb_dat <= d;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    rd_dat = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_i);
    if (n >= 20) begin
      errors++;
      give_verdict();
    end
  endtask : bus

  // Bounded wait for the ramp to settle on a value
  task automatic wait_freq(input logic [15:0] exp);
    int n;
    logic [15:0] f;
    n = 0;
    while (freq !== exp && n < 1500) begin
      @(posedge clk_i);
      n++;
    end
    f = freq;
    check({16'h0, f}, {16'h0, exp});
    if (n >= 1500) begin
      give_verdict();
    end
  endtask : wait_freq

  // Reset values and read-only places
  task automatic t_regs;
    check({31'h0, hold_torque}, 32'h0);
    bus(axis_limit_pkg::OFS_CTRL, 1'b0, 32'h0);
    check(rd_dat, 32'h0);
    bus(axis_limit_pkg::OFS_CTRL, 1'b1, 32'h40);
    check({31'h0, hold_torque}, 32'h1);
    bus(axis_limit_pkg::OFS_CTRL, 1'b1, 32'h0);
    check({31'h0, hold_torque}, 32'h0);
    bus(axis_limit_pkg::OFS_DECEL, 1'b0, 32'h0);
    check(rd_dat, 32'h10);
    bus(axis_limit_pkg::OFS_LIM_DECEL, 1'b0, 32'h0);
    check(rd_dat, 32'h40);
    bus(8'h40, 1'b1, 32'hff);
    bus(8'h40, 1'b0, 32'h0);
    check(rd_dat, 32'h0); // Unmapped reads zero
    bus(axis_limit_pkg::OFS_STATUS, 1'b1, 32'hf);
    bus(axis_limit_pkg::OFS_STATUS, 1'b0, 32'h0);
    check(rd_dat & 32'hf, 32'h0);
  endtask : t_regs

  // Limit polarity, event bits and masked interrupt
  task automatic t_polarity;
    bus(axis_limit_pkg::OFS_STATUS, 1'b0, 32'h0);
    check(rd_dat & 32'h9, 32'h0);
    bus(axis_limit_pkg::OFS_CTRL, 1'b1, 32'h30);
    bus(axis_limit_pkg::OFS_STATUS, 1'b0, 32'h0);
    check(rd_dat & 32'h9, 32'h9);
    bus(axis_limit_pkg::OFS_IRQ_STAT, 1'b0, 32'h0);
    check(rd_dat & 32'h3, 32'h3);
    bus(axis_limit_pkg::OFS_IRQ_MASK, 1'b1, 32'h3);
    check({31'h0, irq}, 32'h1);
    op_u.limit(2'b00, 2'b11);
    bus(axis_limit_pkg::OFS_IRQ_STAT, 1'b1, 32'hf);
    bus(axis_limit_pkg::OFS_STATUS, 1'b0, 32'h0);
    check(rd_dat & 32'h9, 32'h0);
    check({31'h0, irq}, 32'h0);
    bus(axis_limit_pkg::OFS_CTRL, 1'b1, 32'h0);
    op_u.limit(2'b00, 2'b00);
    bus(axis_limit_pkg::OFS_IRQ_STAT, 1'b1, 32'hf);
  endtask : t_polarity

  // Run, limit stop, reverse away, normal stop
  task automatic t_motion;
    bus(axis_limit_pkg::OFS_DECEL, 1'b1, 32'h40);
    op_u.refs(16'h0100, 16'h0);
    repeat (300) @(posedge clk_i);
    check({16'h0, freq}, 32'h0);
    op_u.run(1'b1, 1'b0);
    wait_freq(16'h0100);
    bus(axis_limit_pkg::OFS_DECEL, 1'b1, 32'h1);
    op_u.limit(2'b10, 2'b00);
    wait_freq(16'h0); // Slow normal rate would miss
    bus(axis_limit_pkg::OFS_IRQ_STAT, 1'b0, 32'h0);
    check(rd_dat & 32'h4, 32'h4);
    bus(axis_limit_pkg::OFS_DECEL, 1'b1, 32'h40);
    op_u.run(1'b0, 1'b1);
    wait_freq(16'hff00);
    bus(axis_limit_pkg::OFS_DECEL, 1'b1, 32'h1);
    op_u.run(1'b0, 1'b0);
    repeat (1000) @(posedge clk_i);
    check({31'h0, freq === 16'h0}, 32'h0);
    bus(axis_limit_pkg::OFS_DECEL, 1'b1, 32'h40);
    wait_freq(16'h0);
    op_u.limit(2'b00, 2'b00);
  endtask : t_motion

  // Reference selector settings
  task automatic t_select;
    op_u.refs(16'h0080, 16'h0200);
    op_u.run(1'b1, 1'b0);
    wait_freq(16'h0080);
    bus(axis_limit_pkg::OFS_CTRL, 1'b1, 32'h1);
    op_u.refs(16'h00c0, 16'h0200);
    wait_freq(16'h00c0);
    bus(axis_limit_pkg::OFS_CTRL, 1'b1, 32'h2);
    wait_freq(16'h0100);
    bus(axis_limit_pkg::OFS_CTRL, 1'b1, 32'h3);
    wait_freq(16'h0);
    bus(axis_limit_pkg::OFS_IRQ_STAT, 1'b0, 32'h0);
    check(rd_dat & 32'h8, 32'h8);
    op_u.run(1'b0, 1'b0);
  endtask : t_select

  // Reset for five cycles, then the scenarios
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_polarity();
    t_motion();
    t_select();
    give_verdict();
  end
endmodule : tb_axis_limit_stop_control
